// ==== rtl/bcwc_pkg.sv ====
package bcwc_pkg;

   // ----------------------------------------------------------------
   // operation codes presented by the decode stage
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BCWC_OP_NONE,
      BCWC_OP_BIT_ZERO,
      BCWC_OP_WDT_CLEAR,
      BCWC_OP_PRECLEAR_FIRST,
      BCWC_OP_PRECLEAR_SECOND,
      BCWC_OP_INVERT
   } bcwc_op_e;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int          BCWC_DATA_W       = 8;
   localparam int          BCWC_ADDR_W       = 8;
   localparam int          BCWC_BIT_SEL_W    = 3;
   // pairing record after reset: none taken yet, so either pre-clear acts
   localparam logic [1:0]  BCWC_PAIR_RESET   = 2'h0;
   localparam logic [1:0]  BCWC_PAIR_FIRST   = 2'h1;
   localparam logic [1:0]  BCWC_PAIR_SECOND  = 2'h2;
   localparam logic [7:0]  BCWC_DATA_RESET   = 8'h00;

endpackage : bcwc_pkg

// ==== rtl/bcwc_pair_track.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// pre-clear pairing tracker
// ----------------------------------------------------------------
module bcwc_pair_track
   import bcwc_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic preclear_first,
   input  wire logic preclear_second,
   output logic      preclear_effective
);

   logic [1:0] last_taken;
   logic [1:0] next_last_taken;
   wire        first_ok;
   wire        second_ok;

   // a pre-clear matching the recorded one is ignored
   assign first_ok  = preclear_first && (last_taken != BCWC_PAIR_FIRST);
   assign second_ok = preclear_second && (last_taken != BCWC_PAIR_SECOND);
   assign preclear_effective = first_ok || second_ok;
   assign next_last_taken = first_ok  ? BCWC_PAIR_FIRST :
                            second_ok ? BCWC_PAIR_SECOND :
                                        last_taken;

   // record follows only effective pre-clears
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         last_taken <= BCWC_PAIR_RESET;
      end else begin
         last_taken <= next_last_taken;
      end
   end

endmodule : bcwc_pair_track

// ==== rtl/bcwc_exec.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - bit-zero clears only the chosen bit; other bits and flags untouched.
// - watchdog clear resets counter, expired flag and sleep flag together.
// - pre-clears clear counter and both flags only when alternated, or on the first one after reset.
// - invert writes complemented byte back; only zero flag updates.

module bcwc_exec
   import bcwc_pkg::*;
#(
   parameter int DATA_W = BCWC_DATA_W,
   parameter int ADDR_W = BCWC_ADDR_W
)
(
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire logic                  op_valid,
   input  wire bcwc_op_e              op_code,
   input  wire logic [ADDR_W-1:0]     op_addr,
   input  wire logic [BCWC_BIT_SEL_W-1:0] op_bit,
   input  wire logic [DATA_W-1:0]     mem_rdata,
   output logic                       mem_we,
   output logic [ADDR_W-1:0]          mem_addr,
   output logic [DATA_W-1:0]          mem_wdata,
   output logic                       zero_flag_we,
   output logic                       zero_flag,
   output logic                       watchdog_counter_clear,
   output logic                       watchdog_expired_flag_clear,
   output logic                       sleep_entered_flag_clear
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire              do_bit_zero;
   wire              do_wdt_clear;
   wire              do_pre_first;
   wire              do_pre_second;
   wire              do_invert;
   wire              pre_effective;
   wire              wdt_hit;
   wire [DATA_W-1:0] bit_mask;
   wire [DATA_W-1:0] cleared_byte;
   wire [DATA_W-1:0] inverted_byte;
   wire [DATA_W-1:0] next_wdata;

   assign do_bit_zero   = op_valid && (op_code == BCWC_OP_BIT_ZERO);
   assign do_wdt_clear  = op_valid && (op_code == BCWC_OP_WDT_CLEAR);
   assign do_pre_first  = op_valid && (op_code == BCWC_OP_PRECLEAR_FIRST);
   assign do_pre_second = op_valid && (op_code == BCWC_OP_PRECLEAR_SECOND);
   assign do_invert     = op_valid && (op_code == BCWC_OP_INVERT);

   // ----------------------------------------------------------------
   // data path
   // ----------------------------------------------------------------
   // one-hot mask of the selected bit, built per bit
   genvar g;
   generate
      for (g = 0; g < DATA_W; g++) begin : g_mask
         assign bit_mask[g] = (op_bit == BCWC_BIT_SEL_W'(g));
      end
   endgenerate

   assign cleared_byte  = mem_rdata & ~bit_mask;
   assign inverted_byte = ~mem_rdata;
   assign next_wdata    = do_invert ? inverted_byte : cleared_byte;

   // ----------------------------------------------------------------
   // watchdog pairing
   // ----------------------------------------------------------------
   bcwc_pair_track u_pair (
      .clock              (clock),
      .reset_n            (reset_n),
      .preclear_first     (do_pre_first),
      .preclear_second    (do_pre_second),
      .preclear_effective (pre_effective)
   );

   // single clear always acts; a repeated pre-clear changes nothing
   assign wdt_hit = do_wdt_clear || pre_effective;

   // ----------------------------------------------------------------
   // registered outputs, one cycle after the operation is presented
   // ----------------------------------------------------------------
   // memory write port; flags are left alone by bit-zero
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mem_we    <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= '0;
      end else begin
         mem_we    <= do_bit_zero || do_invert;
         mem_addr  <= op_addr;
         mem_wdata <= next_wdata;
      end
   end

   // zero flag strobes only for invert; held value otherwise
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         zero_flag_we <= 1'b0;
         zero_flag    <= 1'b0;
      end else begin
         zero_flag_we <= do_invert;
         if (do_invert) begin
            zero_flag <= (inverted_byte == '0);
         end
      end
   end

   // watchdog strobes all fire together so no partial clear is seen
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         watchdog_counter_clear      <= 1'b0;
         watchdog_expired_flag_clear <= 1'b0;
         sleep_entered_flag_clear    <= 1'b0;
      end else begin
         watchdog_counter_clear      <= wdt_hit;
         watchdog_expired_flag_clear <= wdt_hit;
         sleep_entered_flag_clear    <= wdt_hit;
      end
   end

endmodule : bcwc_exec

// ==== verification/bcwc_exec_chk.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// execution checker
// ---------------------------------------------------------------
module bcwc_exec_chk
   import bcwc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       op_valid,
   input  wire bcwc_op_e   op_code,
   input  wire logic [7:0] op_addr,
   input  wire logic [2:0] op_bit,
   input  wire logic [7:0] mem_rdata,
   input  wire logic       mem_we,
   input  wire logic [7:0] mem_addr,
   input  wire logic [7:0] mem_wdata,
   input  wire logic       zero_flag_we,
   input  wire logic       zero_flag,
   input  wire logic       watchdog_counter_clear,
   input  wire logic       watchdog_expired_flag_clear,
   input  wire logic       sleep_entered_flag_clear
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // decoded requests; repeats are judged only back to back
   wire logic f1 = op_valid && op_code == BCWC_OP_PRECLEAR_FIRST;
   wire logic f2 = op_valid && op_code == BCWC_OP_PRECLEAR_SECOND;
   wire logic wd = op_valid && op_code == BCWC_OP_WDT_CLEAR;
   wire logic iv = op_valid && op_code == BCWC_OP_INVERT;
   wire logic bz = op_valid && op_code == BCWC_OP_BIT_ZERO;
   AST_BIT_ZERO: assert property (bz |=> mem_we && !zero_flag_we &&
      mem_wdata == ($past(mem_rdata) & ~(8'h01 << $past(op_bit))))
      else $error("bit zero result wrong");
   AST_WDT_CLEAR: assert property (wd |=> watchdog_counter_clear && !mem_we)
      else $error("watchdog clear missing");
   AST_CLEAR_TOGETHER: assert property (watchdog_counter_clear ==
      watchdog_expired_flag_clear && watchdog_counter_clear ==
      sleep_entered_flag_clear) else $error("watchdog strobes split");
   AST_NO_CLEAR: assert property (!(wd || f1 || f2) |=> !watchdog_counter_clear)
      else $error("stray watchdog clear");
   AST_REPEAT: assert property ((f1 ##1 f1) or (f2 ##1 f2)
      |=> !watchdog_counter_clear) else $error("repeat pre-clear acted");
   AST_ALTERNATE: assert property ((f1 ##1 f2) or (f2 ##1 f1)
      |=> watchdog_counter_clear) else $error("alternate pre-clear lost");
   AST_INVERT: assert property (iv |=> mem_we && zero_flag_we &&
      mem_wdata == ~$past(mem_rdata) && mem_addr == $past(op_addr) &&
      zero_flag == (mem_wdata == 8'h00)) else $error("invert wrong");
   AST_ZERO_HOLD: assert property (!iv |=> !zero_flag_we && $stable(zero_flag))
      else $error("zero flag moved");
   cover property (iv ##1 zero_flag);
   cover property (f1 ##1 f2);
   cover property (bz);
endmodule : bcwc_exec_chk

bind bcwc_exec bcwc_exec_chk chk (.clock, .reset_n, .op_valid, .op_code,
   .op_addr, .op_bit, .mem_rdata, .mem_we, .mem_addr, .mem_wdata,
   .zero_flag_we, .zero_flag, .watchdog_counter_clear,
   .watchdog_expired_flag_clear, .sleep_entered_flag_clear);

// ==== verification/bit_clear_wdt_complement_ops_tb_top.sv ====
`timescale 1ns/100ps
module bit_clear_wdt_complement_ops_tb_top;
   import bcwc_pkg::*;
   logic clock = 0, reset_n = 0, op_valid = 0, mem_we, zero_flag_we, zero_flag;
   logic wcc, wec, sec;
   logic [7:0] op_addr = 0, mem_rdata = 0, mem_addr, mem_wdata;
   logic [2:0] op_bit = 0;
   bcwc_op_e   op_code = BCWC_OP_NONE;
   int         n_mismatch = 0, n_tests = 0;
   bcwc_exec uut (.clock, .reset_n, .op_valid, .op_code, .op_addr, .op_bit,
      .mem_rdata, .mem_we, .mem_addr, .mem_wdata, .zero_flag_we, .zero_flag,
      .watchdog_counter_clear(wcc), .watchdog_expired_flag_clear(wec),
      .sleep_entered_flag_clear(sec));
   initial forever #50 clock = ~clock;
   task automatic chk(input logic [19:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // one request per call, answer is looked at one edge later; valid
   // stays up between calls so it is never written twice in one step
   task automatic op(input bcwc_op_e c, input logic [7:0] a, d, input int b);
      op_code = c; op_addr = a; mem_rdata = d; op_bit = 3'(b); op_valid = 1;
      @(posedge clock); #1;
   endtask : op
   task automatic clr(input logic [2:0] e);
      chk({wcc, wec, sec}, e);
   endtask : clr
   task automatic t_pair;
      op(BCWC_OP_PRECLEAR_FIRST, 0, 0, 0);  clr(3'h7);
      op(BCWC_OP_PRECLEAR_FIRST, 0, 0, 0);  clr(3'h0);
      op(BCWC_OP_WDT_CLEAR, 0, 0, 0);       clr(3'h7);
      op(BCWC_OP_PRECLEAR_FIRST, 0, 0, 0);  clr(3'h0);
      op(BCWC_OP_PRECLEAR_SECOND, 0, 0, 0); clr(3'h7);
      op(BCWC_OP_PRECLEAR_SECOND, 0, 0, 0); clr(3'h0);
      op(BCWC_OP_PRECLEAR_FIRST, 0, 0, 0);  clr(3'h7);
   endtask : t_pair
   task automatic t_bit;
      for (int b = 0; b < 8; b++) begin
         op(BCWC_OP_BIT_ZERO, 8'(b + 16), 8'hFF, b);
         chk({mem_we, zero_flag_we, mem_addr, mem_wdata},
            {2'h2, 8'(b + 16), 8'hFF & ~(8'h01 << b)});
      end
   endtask : t_bit
   task automatic t_inv;
      op(BCWC_OP_INVERT, 8'h5A, 8'hFF, 0);
      chk({mem_we, zero_flag_we, zero_flag, mem_wdata}, 20'h700);
      op(BCWC_OP_INVERT, 8'hA5, 8'h0F, 0);
      chk({zero_flag, mem_addr, mem_wdata}, 20'h0A5F0);
      op(BCWC_OP_NONE, 0, 8'hFF, 0);
      chk({mem_we, zero_flag_we, zero_flag, wcc}, 4'h0);
   endtask : t_inv
   task automatic report_and_stop;
      if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20) @(posedge clock);
      #1 reset_n = 1;
      t_pair;
      t_bit;
      t_inv;
      report_and_stop;
   end
   // the run needs about eighteen cycles after reset
   initial begin
      #20000 n_mismatch++;
      report_and_stop;
   end
endmodule : bit_clear_wdt_complement_ops_tb_top
